// [design/sec_pkg.sv]
// Constants and types shared by the two-wire memory command slave
package sec_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int PROG_W = ADDR_W + DATA_W;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_TOP = 9'h1FF;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 9'h001;
	localparam int SEL_RW_BIT = 0;
	localparam int SEL_CS_BIT = 1;
	localparam int SEL_AHI_BIT = 2;
	localparam int SEL_PAD_BIT = 3;
	localparam int SEL_TYPE_LSB = 4;
	localparam int CORE_CLK_HZ = 20000000;
	localparam int TPROG_MAX_MS = 20;
	localparam int MS_PER_S = 1000;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_DEV  = 3'b001,
		ST_ADDR = 3'b010,
		ST_WDAT = 3'b011,
		ST_ACK  = 3'b100,
		ST_RDAT = 3'b101,
		ST_MACK = 3'b110,
		ST_IGN  = 3'b111
	} sec_state_e;
endpackage

// [design/sec_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sec_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,    // Core clock
	input  wire logic             i_rst,    // Async reset, high
	input  wire logic             i_valid,  // Write side valid
	output      logic             o_ready,  // Not full
	input  wire logic [WIDTH-1:0] i_data,   // Write word
	output      logic             o_valid,  // Not empty
	input  wire logic             i_ready,  // Read side takes word
	output      logic [WIDTH-1:0] o_data    // Head word
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
	localparam logic [PW:0] CNT_ONE = (PW+1)'(1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH-1);
	localparam logic [PW-1:0] PTR_ONE = PW'(1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_ONE;
	endfunction

	assign o_ready = (count != CNT_FULL);
	assign o_valid = (count != '0);
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;
	assign o_data = mem[rd_ptr];

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr] <= i_data;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= ptr_inc(wr_ptr);
			if (pop)
				rd_ptr <= ptr_inc(rd_ptr);
			if (push && !pop)
				count <= count + CNT_ONE;
			else if (pop && !push)
				count <= count - CNT_ONE;
		end
	end
endmodule

// [design/sec_slave.sv]
// Two-wire command slave: decodes select, address and data words
`timescale 1ns/10ps
module sec_slave
	import sec_pkg::*;
#(
	// Device type code; value is arbitrary
	parameter logic [3:0] DEV_TYPE = 4'h5,
	parameter int PROG_MAX_CYC = TPROG_MAX_MS * (CORE_CLK_HZ / MS_PER_S)
) (
	input  wire logic                      i_core_clk,   // Core clock
	input  wire logic                      i_rst,        // Async reset, high
	input  wire logic                      i_scl,        // Serial clock pin
	input  wire logic                      i_sda,        // Data line level
	output      logic                      o_sda_out,    // Data drive value
	output      logic                      o_sda_oe_n,   // Low: pull data low
	input  wire logic                      i_cs_sel,     // Chip select strap pin
	output      logic [sec_pkg::ADDR_W-1:0] o_rd_addr,   // Read address
	input  wire logic [sec_pkg::DATA_W-1:0] i_rd_data,   // Read data at o_rd_addr
	output      logic                      o_prog_start, // Program pulse
	output      logic [sec_pkg::ADDR_W-1:0] o_prog_addr, // Program address
	output      logic [sec_pkg::DATA_W-1:0] o_prog_data, // Program data
	output      logic                      o_prog_abort, // Abort pulse
	output      logic                      o_prog_active,// Program pending
	input  wire logic                      i_mem_busy    // Array erasing/writing
);
	import sec_pkg::*;

	logic       scl_s1, scl_s2, scl_s3;
	logic       sda_s1, sda_s2, sda_s3;
	logic       cs_s1, cs_s2;
	logic       scl_rise, scl_fall, start_c, stop_c;
	sec_state_e state;
	sec_state_e after_ack;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic       have_addr;
	logic       wr_full;
	logic       more;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic       byte_end;
	logic       sel_match;
	logic       fifo_in_valid;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic       fifo_out_ready;
	logic [PROG_W-1:0] fifo_out;
	logic [31:0] prog_timer;

	// Logic reads the second and third stages of the clock and data synchronisers, and the second of the select
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{cs_s1, cs_s2} <= 2'h0;
		end
		else
		begin
			{scl_s1, scl_s2, scl_s3} <= {i_scl, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {i_sda, sda_s1, sda_s2};
			{cs_s1, cs_s2} <= {i_cs_sel, cs_s1};
		end
	end

	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	assign start_c = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
	assign stop_c = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
	assign byte_end = scl_fall && (bitcnt == BYTE_BITS);
	assign sel_match = (shreg[7:SEL_TYPE_LSB] == DEV_TYPE)
		&& (shreg[SEL_CS_BIT] == cs_s2);

	// Sequencer, shift register and data line drive
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state <= ST_IDLE;
			after_ack <= ST_IDLE;
			bitcnt <= BIT_ZERO;
			shreg <= 8'h00;
			o_sda_oe_n <= 1'b1;
			more <= 1'b0;
		end
		else if (stop_c)
		begin
			state <= ST_IDLE;
			o_sda_oe_n <= 1'b1;
		end
		else if (start_c)
		begin
			state <= ST_DEV;
			bitcnt <= BIT_ZERO;
			o_sda_oe_n <= 1'b1;
		end
		else
		begin
			case (state)
				ST_DEV, ST_ADDR, ST_WDAT:
				begin
					if (scl_rise)
					begin
						shreg <= {shreg[6:0], sda_s2};
						bitcnt <= bitcnt + BIT_ONE;
					end
					else if (byte_end)
					begin
						state <= ST_IGN;
						if (state == ST_ADDR)
						begin
							o_sda_oe_n <= 1'b0;
							after_ack <= ST_WDAT;
							state <= ST_ACK;
						end
						else if (state == ST_WDAT)
						begin
							o_sda_oe_n <= 1'b0;
							after_ack <= ST_IGN;
							state <= ST_ACK;
						end
						else if (sel_match && !shreg[SEL_RW_BIT] && !wr_full)
						begin
							o_sda_oe_n <= 1'b0;
							after_ack <= ST_ADDR;
							state <= ST_ACK;
						end
						else if (sel_match && shreg[SEL_RW_BIT] && !o_prog_active)
						begin
							// Polls without a word address get the ack but no data
							o_sda_oe_n <= 1'b0;
							after_ack <= have_addr ? ST_RDAT : ST_IGN;
							state <= ST_ACK;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						bitcnt <= BIT_ZERO;
						state <= after_ack;
						o_sda_oe_n <= 1'b1;
						if (after_ack == ST_RDAT)
						begin
							shreg <= i_rd_data;
							o_sda_oe_n <= i_rd_data[7];
						end
					end
				end
				ST_RDAT:
				begin
					if (scl_rise)
						bitcnt <= bitcnt + BIT_ONE;
					else if (byte_end)
					begin
						o_sda_oe_n <= 1'b1;
						state <= ST_MACK;
					end
					else if (scl_fall)
					begin
						o_sda_oe_n <= shreg[6];
						shreg <= {shreg[6:0], 1'b0};
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
						more <= ~sda_s2;
					else if (scl_fall && more)
					begin
						shreg <= i_rd_data;
						o_sda_oe_n <= i_rd_data[7];
						bitcnt <= BIT_ZERO;
						state <= ST_RDAT;
					end
					else if (scl_fall)
						state <= ST_IGN;
				end
				ST_IGN, ST_IDLE:
					o_sda_oe_n <= 1'b1;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Address counter, saturating at the top word
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			addr <= '0;
			have_addr <= 1'b0;
		end
		else if (stop_c)
			have_addr <= 1'b0;
		else if (byte_end && state == ST_DEV && sel_match && !shreg[SEL_RW_BIT]
			&& !wr_full)
			addr[ADDR_W-1] <= shreg[SEL_AHI_BIT];
		else if (byte_end && state == ST_ADDR)
		begin
			addr[7:0] <= shreg;
			have_addr <= 1'b1;
		end
		else if (state == ST_MACK && scl_rise && !sda_s2 && addr != ADDR_TOP)
			addr <= addr + ADDR_ONE;
	end

	assign o_rd_addr = addr;

	// Data latch and commit at stop; a full queue refuses new write-selects
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wdata <= 8'h00;
			fifo_in_valid <= 1'b0;
			o_prog_abort <= 1'b0;
		end
		else
		begin
			fifo_in_valid <= 1'b0;
			o_prog_abort <= 1'b0;
			if (byte_end && state == ST_WDAT)
				wdata <= shreg;
			if (stop_c && state == ST_IGN && after_ack == ST_IGN && have_addr)
				fifo_in_valid <= 1'b1;
			if (byte_end && state == ST_DEV && sel_match && !shreg[SEL_RW_BIT]
				&& !wr_full && o_prog_active)
				o_prog_abort <= 1'b1;
		end
	end

	assign wr_full = ~fifo_in_ready | fifo_in_valid;

	sec_fifo #(
		.WIDTH (PROG_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk   (i_core_clk),
		.i_rst   (i_rst),
		.i_valid (fifo_in_valid),
		.o_ready (fifo_in_ready),
		.i_data  ({addr, wdata}),
		.o_valid (fifo_out_valid),
		.i_ready (fifo_out_ready),
		.o_data  (fifo_out)
	);

	// Array takes one word at a time; busy stalls the queue
	assign fifo_out_ready = ~i_mem_busy & ~o_prog_start & ~o_prog_abort;

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_prog_start <= 1'b0;
			o_prog_addr <= '0;
			o_prog_data <= 8'h00;
			o_sda_out <= 1'b0;
		end
		else
		begin
			o_prog_start <= fifo_out_valid & fifo_out_ready;
			if (fifo_out_valid && fifo_out_ready)
				{o_prog_addr, o_prog_data} <= fifo_out;
		end
	end

	// Program watchdog: a cycle longer than the limit counts as ended
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_prog_active <= 1'b0;
			prog_timer <= 32'h0;
		end
		else if (o_prog_abort)
		begin
			o_prog_active <= 1'b0;
			prog_timer <= 32'h0;
		end
		else if (fifo_in_valid || fifo_out_valid || o_prog_start)
		begin
			o_prog_active <= 1'b1;
			prog_timer <= 32'h0;
		end
		else if (o_prog_active)
		begin
			prog_timer <= prog_timer + 32'h1;
			if (!i_mem_busy || prog_timer >= 32'(PROG_MAX_CYC - 1))
				o_prog_active <= 1'b0;
		end
	end

	sequence s_sel_read_end;
		state == ST_DEV && byte_end && sel_match && shreg[SEL_RW_BIT];
	endsequence

	property p_stop_idle;
		@(posedge i_core_clk) disable iff (i_rst)
		stop_c |=> state == ST_IDLE && o_sda_oe_n;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("stop did not idle the sequencer");

	property p_busy_nack;
		@(posedge i_core_clk) disable iff (i_rst)
		s_sel_read_end and o_prog_active |=> o_sda_oe_n;
	endproperty
	a_busy_nack: assert property (p_busy_nack)
		else $error("read-select acknowledged while programming");

	property p_idle_read_ack;
		@(posedge i_core_clk) disable iff (i_rst)
		s_sel_read_end and !o_prog_active |=> !o_sda_oe_n && state == ST_ACK;
	endproperty
	a_idle_read_ack: assert property (p_idle_read_ack)
		else $error("read-select not acknowledged after programming");

	property p_abort;
		@(posedge i_core_clk) disable iff (i_rst)
		state == ST_DEV && byte_end && sel_match && !shreg[SEL_RW_BIT] && !wr_full
		&& o_prog_active |=> o_prog_abort ##1 !o_prog_active;
	endproperty
	a_abort: assert property (p_abort)
		else $error("write-select did not abort programming");

	property p_commit_on_stop;
		@(posedge i_core_clk) disable iff (i_rst)
		fifo_in_valid |-> $past(stop_c);
	endproperty
	a_commit_on_stop: assert property (p_commit_on_stop)
		else $error("program committed without stop");

	property p_ack_hold;
		@(posedge i_core_clk) disable iff (i_rst)
		state == ST_ACK && !o_sda_oe_n && !scl_fall && !start_c && !stop_c |=> !o_sda_oe_n;
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("acknowledge released early");

	property p_incr;
		@(posedge i_core_clk) disable iff (i_rst)
		state == ST_MACK && scl_rise && !sda_s2 && !stop_c && !start_c |=>
		addr == (($past(addr) == ADDR_TOP) ? ADDR_TOP : $past(addr) + ADDR_ONE);
	endproperty
	a_incr: assert property (p_incr)
		else $error("address did not step or wrapped");

	property p_mack_release;
		@(posedge i_core_clk) disable iff (i_rst)
		state == ST_MACK |-> o_sda_oe_n;
	endproperty
	a_mack_release: assert property (p_mack_release)
		else $error("device drove line during master acknowledge");

	property p_mismatch;
		@(posedge i_core_clk) disable iff (i_rst)
		state == ST_DEV && byte_end && !sel_match && !start_c && !stop_c |=>
		state == ST_IGN && o_sda_oe_n;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("mismatched select not ignored");
endmodule

// [dv/sec_master.sv]
// Two-wire bus master model driving the serial clock and data lines
`timescale 1ns/10ps
module sec_master #(
	parameter int QTR = 12
) (
	input  wire logic i_link_clk, // Link clock
	input  wire logic i_sda,      // Resolved data line
	output      logic o_scl,      // Serial clock drive
	output      logic o_sda       // Data drive, 1 releases
);
	// Clock stands high between frames
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic q();
		repeat (QTR) @(posedge i_link_clk);
	endtask
	// Also serves as repeated start
	task automatic start();
		q();
		o_sda <= 1'b1;
		q();
		o_scl <= 1'b1;
		q();
		o_sda <= 1'b0;
		q();
		o_scl <= 1'b0;
		q();
	endtask
	task automatic stop();
		o_sda <= 1'b0;
		q();
		o_scl <= 1'b1;
		q();
		o_sda <= 1'b1;
		q();
	endtask
	// Data changes only while the clock is low
	task automatic bitx(input logic b, output logic r);
		o_sda <= b;
		q();
		o_scl <= 1'b1;
		q();
		r = i_sda;
		q();
		o_scl <= 1'b0;
		q();
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, ack);
	endtask
	task automatic rd_byte(input logic mack, output logic [7:0] d, output logic rel);
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(mack, rel);
	endtask
endmodule

// [dv/tb_sec_slave.sv]
// Self-checking bench for the two-wire memory command slave
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_sec_slave;
	import sec_pkg::*;
	localparam logic [3:0] TYPE = 4'h5; // Arbitrary type code
	localparam int         BUSY = 2000;
	logic              i_core_clk = 1'b0;
	logic              i_link_clk = 1'b0;
	logic              i_rst = 1'b1;
	logic              i_cs_sel = 1'b0;
	logic [7:0]        mem [512];
	int                busy_cnt = 0;
	int                n_start = 0;
	int                n_abort = 0;
	int                n_errors = 0;
	int                n_tests = 0;
	logic              scl, m_sda, sda, sda_out, sda_oe_n, mem_busy;
	logic              prog_start, prog_abort, prog_active;
	logic [ADDR_W-1:0] rd_addr, prog_addr;
	logic [DATA_W-1:0] rd_data, prog_data;
	always #25 i_core_clk = ~i_core_clk;
	always #7.5 i_link_clk = ~i_link_clk;
	assign sda = m_sda & (sda_oe_n | sda_out);
	assign rd_data = mem[rd_addr];
	assign mem_busy = busy_cnt != 0;
	sec_master m_u (.i_link_clk(i_link_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
	sec_slave #(.DEV_TYPE(TYPE), .PROG_MAX_CYC(4000)) dut_u (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_cs_sel(i_cs_sel),
		.o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_prog_start(prog_start),
		.o_prog_addr(prog_addr), .o_prog_data(prog_data), .o_prog_abort(prog_abort),
		.o_prog_active(prog_active), .i_mem_busy(mem_busy));
	function automatic logic [7:0] pat(input logic [8:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	function automatic logic [7:0] sel(input logic a8, input logic cs, input logic rw);
		return {TYPE, 1'b0, a8, cs, rw};
	endfunction
	initial
		for (int i = 0; i < 512; i++)
			mem[i] = pat(i[8:0]);
	// Erase then write leaves exactly the programmed data
	always @(posedge i_core_clk)
	begin
		if (prog_start === 1'b1)
		begin
			busy_cnt <= BUSY;
			n_start <= n_start + 1;
			mem[prog_addr] <= prog_data;
		end
		else if (prog_abort === 1'b1)
			busy_cnt <= 0;
		else if (busy_cnt != 0)
			busy_cnt <= busy_cnt - 1;
		if (prog_abort === 1'b1)
			n_abort <= n_abort + 1;
	end
	task automatic give_verdict();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic t_write(input logic [8:0] a, input logic [7:0] d);
		logic k0, k1, k2;
		int   s;
		s = n_start;
		m_u.start();
		m_u.wr_byte(sel(a[8], i_cs_sel, 1'b0), k0);
		m_u.wr_byte(a[7:0], k1);
		m_u.wr_byte(d, k2);
		`CHK("write acks", 3'b000, {k0, k1, k2})
		`CHK("active before stop", 1'b0, prog_active)
		m_u.stop();
		for (int i = 0; i < 40 && n_start == s; i++)
			@(posedge i_core_clk);
		`CHK("start count", s + 1, n_start)
		`CHK("prog addr", a, prog_addr)
		`CHK("prog data", d, prog_data)
		$display("test write done");
	endtask
	task automatic t_poll();
		logic       k, r;
		logic [7:0] d;
		m_u.start();
		m_u.wr_byte(sel(1'b0, i_cs_sel, 1'b1), k);
		m_u.stop();
		`CHK("poll busy ack", 1'b1, k)
		for (int i = 0; i < 3000 && prog_active !== 1'b0; i++)
			@(posedge i_core_clk);
		m_u.start();
		m_u.wr_byte(sel(1'b0, i_cs_sel, 1'b1), k);
		m_u.rd_byte(1'b1, d, r);
		m_u.stop();
		`CHK("poll done ack", 1'b0, k)
		$display("test poll done");
	endtask
	task automatic t_read(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
		logic       k0, k1, k2, r0, r1;
		logic [7:0] d0, d1;
		m_u.start();
		m_u.wr_byte(sel(a[8], i_cs_sel, 1'b0), k0);
		m_u.wr_byte(a[7:0], k1);
		m_u.start();
		m_u.wr_byte(sel(a[8], i_cs_sel, 1'b1), k2);
		m_u.rd_byte(1'b0, d0, r0);
		m_u.rd_byte(1'b1, d1, r1);
		m_u.stop();
		repeat (4) @(posedge i_core_clk);
		`CHK("read acks", 3'b000, {k0, k1, k2})
		`CHK("byte 0", e0, d0)
		`CHK("byte 1", e1, d1)
		`CHK("master ack line", 1'b1, r1)
		`CHK("released after stop", 1'b1, sda_oe_n)
		$display("test read done");
	endtask
	task automatic t_cs();
		logic k0, k1, k2;
		@(posedge i_core_clk);
		i_cs_sel <= 1'b1;
		m_u.start();
		m_u.wr_byte(sel(1'b0, 1'b0, 1'b0), k0);
		m_u.wr_byte(8'h00, k1);
		m_u.start();
		m_u.wr_byte({~TYPE, 4'h2}, k2);
		m_u.stop();
		`CHK("refused acks", 3'b111, {k0, k1, k2})
		t_read(9'h055, pat(9'h055), pat(9'h056));
		@(posedge i_core_clk);
		i_cs_sel <= 1'b0;
		$display("test select done");
	endtask
	task automatic t_abort();
		logic k;
		int   s;
		t_write(9'h010, 8'h00);
		s = n_abort;
		m_u.start();
		m_u.wr_byte(sel(1'b0, i_cs_sel, 1'b0), k);
		m_u.stop();
		`CHK("abort count", s + 1, n_abort)
		`CHK("abort ack", 1'b0, k)
		`CHK("active after abort", 1'b0, prog_active)
		$display("test abort done");
	endtask
	initial
	begin
		#2000000;
		n_errors++;
		$display("watchdog expired");
		give_verdict();
	end
	initial
	begin
		repeat (10) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		t_read(9'h1A5, pat(9'h1A5), pat(9'h1A6));
		t_write(9'h1A5, 8'h3C);
		t_poll();
		t_read(9'h1A5, 8'h3C, pat(9'h1A6));
		t_read(9'h1FF, pat(9'h1FF), pat(9'h1FF));
		t_cs();
		t_abort();
		give_verdict();
	end
endmodule
